// ### logic/bls_pkg.sv
// package for the bootloader entry/exit sequencer
// assumes a single 50 MHz clock domain

package bls_pkg;

  localparam int unsigned CLK_HZ           = 50_000_000;
  // least time the enable level must stand after reset release, in ns
  localparam int unsigned EN_HOLD_NS       = 100;
  localparam int unsigned EN_HOLD_CYC      = (EN_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PWD_W            = 32;
  localparam logic [31:0] PWD_RESET        = 32'h0000_0000;

  // which serial loader image is resident
  typedef enum logic [1:0] {
    BLS_LDR_CORE_TIMER = 2'b00,
    BLS_LDR_IO_SERIAL  = 2'b01
  } bls_loader_type;

  typedef enum logic [1:0] {
    BLS_ST_RESET  = 2'b00,
    BLS_ST_SAMPLE = 2'b01,
    BLS_ST_APP    = 2'b10,
    BLS_ST_LOADER = 2'b11
  } bls_state_type;

  typedef struct packed {
    logic in_loader;
    logic mem_unlocked;
    logic uart_channel_sel;
    logic io_interface_sel;
  } bls_status_type;

endpackage : bls_pkg

// ### logic/bls_sequencer.sv
// top of the bootloader entry/exit sequencer
// assumes pins arrive asynchronously; password, its valid flag and expected key come from loader logic on i_clk

`timescale 1ns/100ps
`default_nettype none

module bls_sequencer #(
  parameter int unsigned HOLD_CYC = bls_pkg::EN_HOLD_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_io_reset_pin_n,
  input  wire logic                    i_core_domain_reset_pin_n,
  input  wire logic                    i_loader_enable_pin,
  input  wire logic                    i_loader_enable_pin_oe,
  input  wire logic                    i_test_entry_pin,
  input  wire logic                    i_io_loader_installed,
  input  wire logic                    i_pwd_valid,
  input  wire logic [bls_pkg::PWD_W-1:0] i_pwd,
  input  wire logic [bls_pkg::PWD_W-1:0] i_pwd_expected,
  output logic                         o_device_reset_n,
  output logic                         o_in_loader,
  output logic                         o_mem_access_ok,
  output logic                         o_uart_channel_sel,
  output logic                         o_io_interface_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage is read only by the second, and by pull_down_a for enable
  logic [1:0] io_rst_sync_reg;
  logic [1:0] core_rst_sync_reg;
  logic [1:0] en_sync_reg;
  logic [1:0] test_sync_reg;

  // undriven enable reads low, as the pull-down would make it
  wire en_pin_level = i_loader_enable_pin_oe & i_loader_enable_pin;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      io_rst_sync_reg   <= 2'b00;
      core_rst_sync_reg <= 2'b00;
      en_sync_reg       <= 2'b00;
      test_sync_reg     <= 2'b00;
    end else begin
      io_rst_sync_reg   <= {io_rst_sync_reg[0], i_io_reset_pin_n};
      core_rst_sync_reg <= {core_rst_sync_reg[0], i_core_domain_reset_pin_n};
      en_sync_reg       <= {en_sync_reg[0], en_pin_level};
      test_sync_reg     <= {test_sync_reg[0], i_test_entry_pin};
    end
  end

  wire io_rst_n   = io_rst_sync_reg[1];
  wire core_rst_n = core_rst_sync_reg[1];
  wire any_rst    = !io_rst_n || !core_rst_n;

  // io interface only when its loader is installed; else core pins decide
  wire use_io     = i_io_loader_installed;
  // each interface sees only its own entry pin; either reset pin resets both
  wire entry_lvl  = use_io ? en_sync_reg[1] : test_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // entry / exit decision at reset release
  bls_pkg::bls_state_type state_reg;
  bls_pkg::bls_state_type state_next;
  logic [15:0] hold_cnt_reg;
  logic [15:0] hold_cnt_next;

  wire hold_done = (hold_cnt_reg >= 16'(HOLD_CYC));

  always_comb begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (any_rst) begin
      state_next    = bls_pkg::BLS_ST_RESET;
      hold_cnt_next = 16'h0000;
    end else begin
      unique case (state_reg)
        bls_pkg::BLS_ST_RESET: begin
          state_next    = bls_pkg::BLS_ST_SAMPLE;
          hold_cnt_next = 16'h0000;
        end
        bls_pkg::BLS_ST_SAMPLE: begin
          // a drop of enable before the hold time ends means application start
          if (!entry_lvl) begin
            state_next = bls_pkg::BLS_ST_APP;
          end else if (hold_done) begin
            state_next = bls_pkg::BLS_ST_LOADER;
          end else begin
            hold_cnt_next = hold_cnt_reg + 16'h0001;
          end
        end
        // enable may fall later without leaving the loader
        bls_pkg::BLS_ST_APP:    state_next = state_reg;
        bls_pkg::BLS_ST_LOADER: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg    <= bls_pkg::BLS_ST_RESET;
      hold_cnt_reg <= 16'h0000;
    end else begin
      state_reg    <= state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // password gate; cleared by any reset
  logic unlock_reg;
  wire  pwd_ok = i_pwd_valid && (i_pwd == i_pwd_expected);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unlock_reg <= 1'b0;
    end else if (state_reg != bls_pkg::BLS_ST_LOADER) begin
      unlock_reg <= 1'b0;
    end else if (pwd_ok) begin
      unlock_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  bls_pkg::bls_status_type status_next;
  assign status_next.in_loader        = (state_next == bls_pkg::BLS_ST_LOADER);
  // judged on the next state so access drops on the same edge as loader mode
  assign status_next.mem_unlocked     = unlock_reg && (state_next == bls_pkg::BLS_ST_LOADER);
  assign status_next.uart_channel_sel = 1'b1;
  assign status_next.io_interface_sel = use_io;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_device_reset_n   <= 1'b0;
      o_in_loader        <= 1'b0;
      o_mem_access_ok    <= 1'b0;
      o_uart_channel_sel <= 1'b0;
      o_io_interface_sel <= 1'b0;
    end else begin
      o_device_reset_n   <= !any_rst;
      o_in_loader        <= status_next.in_loader;
      o_mem_access_ok    <= status_next.mem_unlocked;
      o_uart_channel_sel <= status_next.uart_channel_sel;
      o_io_interface_sel <= status_next.io_interface_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  reset_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    any_rst |=> !o_device_reset_n) else $error("device left reset while a reset pin was low");
  mem_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_mem_access_ok |-> o_in_loader) else $error("memory access granted outside loader");
  no_pwd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg != bls_pkg::BLS_ST_LOADER) |=> !unlock_reg) else $error("unlock survived loader exit");
  enter_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_SAMPLE && entry_lvl && hold_done && !any_rst)
      |=> o_in_loader) else $error("loader not entered with enable high");
  exit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_SAMPLE && !entry_lvl && !any_rst)
      |=> state_reg == bls_pkg::BLS_ST_APP) else $error("application not started with enable low");
  hold_time_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(state_reg == bls_pkg::BLS_ST_LOADER) |-> $past(hold_cnt_reg) >= 16'(HOLD_CYC))
    else $error("loader entered before enable hold time");
  sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_LOADER && !any_rst) |=> state_reg == bls_pkg::BLS_ST_LOADER)
    else $error("loader left without a reset pulse");
  uart_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(i_resetn) |-> ##1 o_uart_channel_sel) else $error("uart channel not selected");
  iface_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ##1 (o_io_interface_sel == $past(use_io))) else $error("interface select mismatch");

  ////////////////////////////////////////////////////////////////////////////
  // check helper: consecutive cycles of a high decision level out of reset;
  // kept apart from hold_cnt_reg so the hold check does not lean on it
  logic [15:0] lvl_run_reg;
  wire         lvl_run_max = (lvl_run_reg == 16'hffff);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lvl_run_reg <= 16'h0000;
    end else if (any_rst || !entry_lvl) begin
      lvl_run_reg <= 16'h0000;
    end else if (!lvl_run_max) begin
      lvl_run_reg <= lvl_run_reg + 16'h0001;
    end
  end

  hold_run_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(state_reg == bls_pkg::BLS_ST_LOADER) |-> $past(lvl_run_reg) > 16'(HOLD_CYC))
    else $error("loader entered on a short enable level");
  rst_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_device_reset_n |-> (!o_in_loader && !o_mem_access_ok)) else $error("mode shown while in reset");
  io_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_SAMPLE && use_io && !en_sync_reg[1] && !any_rst)
      |=> state_reg == bls_pkg::BLS_ST_APP) else $error("io interface ignored its enable pin");
  core_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_SAMPLE && !use_io && !test_sync_reg[1] && !any_rst)
      |=> state_reg == bls_pkg::BLS_ST_APP) else $error("core interface ignored its test pin");
  pull_down_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_loader_enable_pin_oe |=> !en_sync_reg[0]) else $error("undriven enable read high");
  app_sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_APP && !any_rst) |=> state_reg == bls_pkg::BLS_ST_APP)
    else $error("application left without a reset pulse");
  no_unlock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == bls_pkg::BLS_ST_LOADER && !pwd_ok && !unlock_reg) |=> !unlock_reg)
    else $error("unlock without a matching password");

endmodule : bls_sequencer

`default_nettype wire

// ### bench/bls_host_model.sv
// programming host model: drives both reset pins, the enable pin and the test pin
// assumes the bench calls its tasks; pins change 1 ns after i_clk rises
`timescale 1ns/100ps
`default_nettype none
module bls_host_model (
  input  wire logic i_clk,
  output logic      o_io_rst_n,
  output logic      o_core_rst_n,
  output logic      o_en,
  output logic      o_en_oe,
  output logic      o_test
);
  initial {o_io_rst_n, o_core_rst_n, o_en, o_en_oe, o_test} = 5'h18;
  task automatic drive(input logic io_n, core_n, en, oe, tst);
    @(posedge i_clk);
    #1;
    {o_io_rst_n, o_core_rst_n, o_en_oe, o_test} = {io_n, core_n, oe, tst};
    o_en = en & oe;
  endtask : drive
  // high-low-high on the chosen reset pin, decision level held past release
  task automatic pulse(input logic io, en, oe, tst);
    drive(!io, io, en, oe, tst);
    repeat (4) @(posedge i_clk);
    drive(1'b1, 1'b1, en, oe, tst);
    repeat (12) @(posedge i_clk);
    // levels drop once the decision is taken, to show they need not stay
    drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask : pulse
endmodule : bls_host_model
`default_nettype wire

// ### bench/bls_sequencer_test.sv
// bench for the entry/exit sequencer, host model on the pin side
// assumes HOLD_CYC of 1; password compare input tied to a fixed key
`timescale 1ns/100ps
`default_nettype none
module bls_sequencer_test;
  logic        i_clk, i_resetn, io_n, core_n, en, oe, tst, inst, pv;
  logic        dev_n, in_ldr, mem_ok, uart, io_sel;
  logic [31:0] pwd;
  int          n_mismatch = 0;
  int          comparisons = 0;
  localparam logic [31:0] KEY = 32'h5a5a_c3c3;
  bls_host_model host (.i_clk(i_clk), .o_io_rst_n(io_n), .o_core_rst_n(core_n),
    .o_en(en), .o_en_oe(oe), .o_test(tst));
  bls_sequencer #(.HOLD_CYC(1)) uut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_io_reset_pin_n(io_n), .i_core_domain_reset_pin_n(core_n),
    .i_loader_enable_pin(en), .i_loader_enable_pin_oe(oe), .i_test_entry_pin(tst),
    .i_io_loader_installed(inst), .i_pwd_valid(pv), .i_pwd(pwd), .i_pwd_expected(KEY),
    .o_device_reset_n(dev_n), .o_in_loader(in_ldr), .o_mem_access_ok(mem_ok),
    .o_uart_channel_sel(uart), .o_io_interface_sel(io_sel));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input string what, input logic seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic offer(input logic [31:0] v);
    @(posedge i_clk);
    #1;
    {pwd, pv} = {v, 1'b1};
    @(posedge i_clk);
    #1;
    pv = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : offer
  task automatic test_io_entry;
    inst = 1'b1;
    host.pulse(1'b1, 1'b1, 1'b1, 1'b0);
    chk("in_loader", in_ldr, 1'b1);
    chk("io_sel", io_sel, 1'b1);
    chk("uart_sel", uart, 1'b1);
    chk("mem_ok", mem_ok, 1'b0);
    offer(KEY ^ 32'h0000_0001);
    chk("mem_ok", mem_ok, 1'b0);
    offer(KEY);
    chk("mem_ok", mem_ok, 1'b1);
    $display("test io entry done");
  endtask : test_io_entry
  task automatic test_io_exit;
    host.pulse(1'b1, 1'b0, 1'b1, 1'b0);
    chk("in_loader", in_ldr, 1'b0);
    chk("mem_ok", mem_ok, 1'b0);
    offer(KEY);
    chk("mem_ok", mem_ok, 1'b0);
    host.pulse(1'b1, 1'b1, 1'b0, 1'b0);
    chk("in_loader", in_ldr, 1'b0);
    host.pulse(1'b1, 1'b0, 1'b1, 1'b1);
    chk("in_loader", in_ldr, 1'b0);
    $display("test io exit done");
  endtask : test_io_exit
  task automatic test_core;
    inst = 1'b0;
    host.pulse(1'b0, 1'b0, 1'b0, 1'b1);
    chk("in_loader", in_ldr, 1'b1);
    chk("io_sel", io_sel, 1'b0);
    host.pulse(1'b0, 1'b1, 1'b1, 1'b0);
    chk("in_loader", in_ldr, 1'b0);
    $display("test core done");
  endtask : test_core
  task automatic test_reset_hold;
    host.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    #1;
    chk("dev_rst_n", dev_n, 1'b0);
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    #1;
    chk("dev_rst_n", dev_n, 1'b0);
    host.drive(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    #1;
    chk("dev_rst_n", dev_n, 1'b1);
    $display("test reset hold done");
  endtask : test_reset_hold
  initial begin
    {i_resetn, inst, pv, pwd} = 35'h0;
    repeat (12) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    test_io_entry();
    test_io_exit();
    test_core();
    test_reset_hold();
    give_verdict();
  end
  // whole run needs about 160 cycles
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end
endmodule : bls_sequencer_test
`default_nettype wire
